// file: dma_flag_consts.svh
// Constants for the stream event flag bank: offsets, field positions, resets.
// Assumes inclusion by the flag bank modules and the bench.
`ifndef DMA_FLAG_CONSTS_SVH
`define DMA_FLAG_CONSTS_SVH
`define OFS_LOW_STATUS   5'h00
`define OFS_HIGH_STATUS  5'h04
`define OFS_LOW_CLEAR    5'h08
`define OFS_HIGH_CLEAR   5'h0c
`define OFS_IRQ_ENABLE   5'h10
`define OFS_IRQ_STATUS   5'h14
`define OFS_IRQ_MASK     5'h18
`define ADDR_W           5
`define GROUP_W          6
`define FLAG_POS_QUEUE   0
`define FLAG_POS_DIRECT  2
`define FLAG_POS_FAULT   3
`define FLAG_POS_HALF    4
`define FLAG_POS_DONE    5
`define GROUP_BASE0      0
`define GROUP_BASE1      6
`define GROUP_BASE2      16
`define GROUP_BASE3      22
// Reserved bits 31:28, 23, 17, 15:12, 7 and 1 stay out of every flag word
`define FLAG_MASK        32'h0f7d_0f7d
`define WORD_ZERO        32'h0000_0000
`define IRQ_MASK_W       8
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// file: dma_flag_pkg.sv
// Types shared by the stream event flag bank.
// Assumes the constants header sits in the same folder.
`default_nettype none
package dma_flag_pkg;
  typedef logic [4:0] stream_events_t;
  typedef enum logic [1:0] {WR_IDLE, WR_RESP} wr_state_t;
endpackage : dma_flag_pkg
`default_nettype wire

// file: dma_stream_flags.sv
// One status word of four stream groups with set-wins clearing.
// Assumes event pulses synchronous to aclk.
`default_nettype none
`include "dma_flag_consts.svh"
module dma_stream_flags
  import dma_flag_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Events and clear
  input  wire logic [19:0] set_events,
  input  wire logic [31:0] clear_bits,
  // Status
  output logic      [31:0] status
);
  function automatic logic [31:0] spread(input logic [19:0] ev);
    logic [31:0] w;
    w = `WORD_ZERO;
    w[`GROUP_BASE0 +: `GROUP_W] = {ev[4:1], 1'b0, ev[0]};
    w[`GROUP_BASE1 +: `GROUP_W] = {ev[9:6], 1'b0, ev[5]};
    w[`GROUP_BASE2 +: `GROUP_W] = {ev[14:11], 1'b0, ev[10]};
    w[`GROUP_BASE3 +: `GROUP_W] = {ev[19:16], 1'b0, ev[15]};
    return w;
  endfunction : spread

  logic [31:0] set_word;
  assign set_word = spread(set_events);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status <= `WORD_ZERO;
    else
      // Set after clear so a same-cycle event survives
      status <= ((status & ~clear_bits) | set_word) & `FLAG_MASK;
  end

  property p_set_wins;
    @(posedge aclk) disable iff (!aresetn)
      (set_word != `WORD_ZERO) |=> ((status & $past(set_word)) == $past(set_word));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");
endmodule : dma_stream_flags
`default_nettype wire

// file: dma_stream_event_flag_bank.sv
// Event flag bank of an eight-stream DMA engine with AXI4-Lite access.
// Assumes stream engines pulse events on aclk; enables come from stream config.
`default_nettype none
`include "dma_flag_consts.svh"
module dma_stream_event_flag_bank
  import dma_flag_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Stream events, five per stream: done,half,fault,direct,queue at 4..0
  input  wire logic [39:0] stream_events,
  // Per-stream interrupt enables, same five-bit layout
  input  wire logic [39:0] stream_irq_enable,
  // Interrupt outputs
  output logic [7:0]       stream_irq,
  output logic             irq
);
  // ****************************************
  // Write channel
  // ****************************************
  logic [4:0]  aw_addr;
  logic        aw_have;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_have;
  wr_state_t   wr_state;
  logic        wr_fire;

  assign s_axi_awready = !aw_have && wr_state == WR_IDLE;
  assign s_axi_wready  = !w_have && wr_state == WR_IDLE;
  assign wr_fire = aw_have && w_have && wr_state == WR_IDLE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have <= 1'b0;
      aw_addr <= 5'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_have <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have <= 1'b0;
      w_data <= `WORD_ZERO;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_have <= 1'b0;
  end

  // Partial strobes refused: clearing half a word could drop events silently
  function automatic logic wr_ok(input logic [4:0] a, input logic [3:0] s);
    logic hit;
    hit = a == 5'(`OFS_LOW_STATUS) || a == 5'(`OFS_HIGH_STATUS) ||
          a == 5'(`OFS_LOW_CLEAR) || a == 5'(`OFS_HIGH_CLEAR) ||
          a == `OFS_IRQ_STATUS || a == `OFS_IRQ_MASK || a == `OFS_IRQ_ENABLE;
    return hit && s == 4'hf;
  endfunction : wr_ok

  logic wr_good;
  assign wr_good = wr_ok(aw_addr, w_strb);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state <= WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      case (wr_state)
        WR_IDLE:
          if (wr_fire)
          begin
            wr_state <= WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_good ? `RESP_OKAY : `RESP_SLVERR;
          end
        WR_RESP:
          if (s_axi_bready)
          begin
            wr_state <= WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        default:
          wr_state <= WR_IDLE;
      endcase
    end
  end

  // ****************************************
  // Flag words
  // ****************************************
  logic [31:0] low_clear_bits;
  logic [31:0] high_clear_bits;
  logic [31:0] low_stream_event_status;
  logic [31:0] high_stream_event_status;

  // Status words are read-only: writes there only answer
  assign low_clear_bits = (wr_fire && wr_good && aw_addr == 5'(`OFS_LOW_CLEAR))
                          ? w_data : `WORD_ZERO;
  assign high_clear_bits = (wr_fire && wr_good && aw_addr == 5'(`OFS_HIGH_CLEAR))
                           ? w_data : `WORD_ZERO;

  dma_stream_flags u_low_flags (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .set_events (stream_events[19:0]),
    .clear_bits (low_clear_bits),
    .status     (low_stream_event_status)
  );

  dma_stream_flags u_high_flags (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .set_events (stream_events[39:20]),
    .clear_bits (high_clear_bits),
    .status     (high_stream_event_status)
  );

  // ****************************************
  // Stream interrupts
  // ****************************************
  function automatic stream_events_t group_of(input logic [31:0] w, input int g);
    logic [5:0] f;
    f = 6'h00;
    case (g)
      0: f = w[`GROUP_BASE0 +: `GROUP_W];
      1: f = w[`GROUP_BASE1 +: `GROUP_W];
      2: f = w[`GROUP_BASE2 +: `GROUP_W];
      3: f = w[`GROUP_BASE3 +: `GROUP_W];
      default: f = 6'h00;
    endcase
    return {f[`FLAG_POS_DONE], f[`FLAG_POS_HALF], f[`FLAG_POS_FAULT],
            f[`FLAG_POS_DIRECT], f[`FLAG_POS_QUEUE]};
  endfunction : group_of

  logic [7:0] stream_req;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      stream_req[i] = |(group_of(low_stream_event_status, i) &
                        stream_irq_enable[5*i +: 5]);
      stream_req[i+4] = |(group_of(high_stream_event_status, i) &
                          stream_irq_enable[5*(i+4) +: 5]);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stream_irq <= 8'h00;
    else
      stream_irq <= stream_req;
  end

  // Sticky rising-edge record per stream, write one to clear, mask gates irq
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] req_prev;
  logic [7:0] req_rise;
  assign req_rise = stream_req & ~req_prev;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      req_prev <= 8'h00;
    else
      req_prev <= stream_req;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status <= 8'h00;
    else if (wr_fire && wr_good && aw_addr == `OFS_IRQ_STATUS)
      irq_status <= (irq_status & ~w_data[`IRQ_MASK_W-1:0]) | req_rise;
    else
      irq_status <= irq_status | req_rise;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask <= 8'h00;
    else if (wr_fire && wr_good && aw_addr == `OFS_IRQ_MASK)
      irq_mask <= w_data[`IRQ_MASK_W-1:0];
  end

  assign irq = |(irq_status & irq_mask);

  // ****************************************
  // Read channel
  // ****************************************
  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      5'(`OFS_LOW_STATUS):  rd_word = low_stream_event_status;
      5'(`OFS_HIGH_STATUS): rd_word = high_stream_event_status;
      5'(`OFS_LOW_CLEAR):   rd_word = `WORD_ZERO;
      5'(`OFS_HIGH_CLEAR):  rd_word = `WORD_ZERO;
      `OFS_IRQ_STATUS:      rd_word = {24'h000000, irq_status};
      `OFS_IRQ_MASK:        rd_word = {24'h000000, irq_mask};
      `OFS_IRQ_ENABLE:      rd_word = `WORD_ZERO;
      default:
      begin
        rd_word = `WORD_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `WORD_ZERO;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word & `FLAG_MASK | (rd_hit &&
                     s_axi_araddr >= `OFS_IRQ_ENABLE ? rd_word : `WORD_ZERO);
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_low_clear;
    @(posedge aclk) disable iff (!aresetn)
      (low_clear_bits != `WORD_ZERO && stream_events[19:0] == 20'h00000)
      |=> ((low_stream_event_status & $past(low_clear_bits)) == `WORD_ZERO);
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("low clear failed");

  property p_high_clear;
    @(posedge aclk) disable iff (!aresetn)
      (high_clear_bits != `WORD_ZERO && stream_events[39:20] == 20'h00000)
      |=> ((high_stream_event_status & $past(high_clear_bits)) == `WORD_ZERO);
  endproperty
  a_high_clear: assert property (p_high_clear) else $error("high clear failed");

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
      ((low_stream_event_status | high_stream_event_status) & ~`FLAG_MASK) == `WORD_ZERO;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_done_set;
    @(posedge aclk) disable iff (!aresetn)
      stream_events[4] |=> low_stream_event_status[`GROUP_BASE0 + `FLAG_POS_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_half_set;
    @(posedge aclk) disable iff (!aresetn)
      stream_events[28] |=> high_stream_event_status[`GROUP_BASE1 + `FLAG_POS_HALF];
  endproperty
  a_half_set: assert property (p_half_set) else $error("half flag not set");

  property p_fault_set;
    @(posedge aclk) disable iff (!aresetn)
      stream_events[12] |=> low_stream_event_status[`GROUP_BASE2 + `FLAG_POS_FAULT];
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault flag not set");

  property p_direct_set;
    @(posedge aclk) disable iff (!aresetn)
      stream_events[36] |=> high_stream_event_status[`GROUP_BASE3 + `FLAG_POS_DIRECT];
  endproperty
  a_direct_set: assert property (p_direct_set) else $error("direct flag not set");

  property p_queue_set;
    @(posedge aclk) disable iff (!aresetn)
      stream_events[5] |=> low_stream_event_status[`GROUP_BASE1 + `FLAG_POS_QUEUE];
  endproperty
  a_queue_set: assert property (p_queue_set) else $error("queue flag not set");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
      (low_clear_bits == `WORD_ZERO) |=>
        ((low_stream_event_status & $past(low_stream_event_status))
          == $past(low_stream_event_status));
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without clear");

  property p_irq_follow;
    @(posedge aclk) disable iff (!aresetn)
      ##1 stream_irq == $past(stream_req);
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("stream irq wrong");

  property p_reset_zero;
    @(posedge aclk) !aresetn |=> (low_stream_event_status == `WORD_ZERO &&
                                  high_stream_event_status == `WORD_ZERO);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("flags not cleared");

  property p_clear_reads_zero;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == 5'(`OFS_LOW_CLEAR))
      |=> s_axi_rdata == `WORD_ZERO;
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear read nonzero");

  property p_bad_strobe;
    @(posedge aclk) disable iff (!aresetn)
      (wr_fire && w_strb != 4'hf) |=> s_axi_bresp == `RESP_SLVERR;
  endproperty
  a_bad_strobe: assert property (p_bad_strobe) else $error("partial write accepted");

  c_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  c_irq: cover property (@(posedge aclk) irq);
  c_set_clear: cover property (@(posedge aclk) stream_events[0] && low_clear_bits[0]);
endmodule : dma_stream_event_flag_bank
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the stream event flag bank, driven over AXI4-Lite.
// Assumes the constants header, package and flag bank modules compile first.
`default_nettype none
`include "dma_flag_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // Signals and design
  // ********
  logic        aclk, aresetn;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, irq;
  logic [39:0] stream_events, stream_irq_enable, en, ev, ne;
  logic [7:0]  stream_irq;
  logic [31:0] lo, hi, rv;
  logic [15:0] seed;
  int          fail_count, checks_done, cycles;

  dma_stream_event_flag_bank u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .stream_events(stream_events), .stream_irq_enable(stream_irq_enable),
    .stream_irq(stream_irq), .irq(irq)
  );

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Hang guard: the whole sequence needs a few hundred cycles
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      results();
    end
  end

  // ********
  // Model, bus tasks and comparison
  // ********
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  function automatic int pos(input int s, input int e);
    int base[4] = '{0, 6, 16, 22};
    int off[5] = '{0, 2, 3, 4, 5};
    return base[s % 4] + off[e];
  endfunction : pos

  function automatic logic [7:0] exp_sirq();
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 40; i++)
      r[i / 5] |= (i < 20 ? lo[pos(i / 5, i % 5)] : hi[pos(i / 5, i % 5)]) & en[i];
    return r;
  endfunction : exp_sirq

  task automatic rnd(output logic [31:0] r);
    seed = lfsr(seed);
    r[15:0] = seed;
    seed = lfsr(seed);
    r[31:16] = seed;
  endtask : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic wr_chk(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] rexp);
    logic [1:0] r;
    axi_write(a, d, s, r);
    check(32'(r), 32'(rexp));
  endtask : wr_chk

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    check(s_axi_rdata, exp);
    check(32'(s_axi_rresp), 32'(rexp));
    s_axi_rready <= 1'b0;
  endtask : rd_chk

  // One-cycle event burst; request outputs settle one edge after the flags
  task automatic pulse(input logic [39:0] e, input logic [39:0] n);
    @(posedge aclk);
    stream_events <= e;
    stream_irq_enable <= n;
    en = n;
    @(posedge aclk);
    stream_events <= '0;
    for (int i = 0; i < 40; i++)
      if (e[i] && i < 20) lo[pos(i / 5, i % 5)] = 1'b1;
      else if (e[i]) hi[pos(i / 5, i % 5)] = 1'b1;
    @(posedge aclk);
    @(negedge aclk);
    check(32'(stream_irq), 32'(exp_sirq()));
  endtask : pulse

  task automatic chk_irq(input logic exp);
    @(negedge aclk);
    check(32'(irq), 32'(exp));
  endtask : chk_irq

  task automatic results();
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // ********
  // Sequence
  // ********
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_wdata, s_axi_wstrb, s_axi_arvalid, s_axi_rready} = '0;
    {stream_events, stream_irq_enable, en, lo, hi} = '0;
    aresetn = 1'b0;
    seed = 16'h0018;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 7; a++)
      rd_chk(5'(a * 4), '0, `RESP_OKAY);
    for (int i = 0; i < 40; i++)
    begin
      rd_chk(i < 20 ? `OFS_LOW_STATUS : `OFS_HIGH_STATUS, i < 20 ? lo : hi, `RESP_OKAY);
      pulse(40'h1 << i, '0);
    end
    rd_chk(`OFS_HIGH_STATUS, hi, `RESP_OKAY);
    wr_chk(`OFS_LOW_STATUS, `FLAG_MASK, 4'hf, `RESP_OKAY);
    wr_chk(`OFS_LOW_CLEAR, `FLAG_MASK, 4'h3, `RESP_SLVERR);
    rd_chk(`OFS_LOW_STATUS, lo, `RESP_OKAY);
    rd_chk(`OFS_LOW_CLEAR, '0, `RESP_OKAY);
    rd_chk(5'h1c, '0, `RESP_SLVERR);
    for (int k = 0; k < 8; k++)
    begin
      rnd(rv);
      ev[31:0] = rv;
      ev[39:32] = rv[23:16];
      rnd(rv);
      ne = {rv[7:0], rv};
      pulse(ev, ne);
      rnd(rv);
      rv &= `FLAG_MASK;
      if (k == 3) rv = '0;
      wr_chk(k[0] ? `OFS_HIGH_CLEAR : `OFS_LOW_CLEAR, rv, 4'hf, `RESP_OKAY);
      if (k[0]) hi &= ~rv;
      else lo &= ~rv;
      rd_chk(`OFS_LOW_STATUS, lo, `RESP_OKAY);
      rd_chk(`OFS_HIGH_STATUS, hi, `RESP_OKAY);
      pulse('0, ne);
    end
    // Clean slate before the interrupt path, sticky status included
    wr_chk(`OFS_LOW_CLEAR, `FLAG_MASK, 4'hf, `RESP_OKAY);
    wr_chk(`OFS_HIGH_CLEAR, `FLAG_MASK, 4'hf, `RESP_OKAY);
    {lo, hi} = '0;
    pulse('0, '0);
    wr_chk(`OFS_IRQ_STATUS, 32'h0000_00ff, 4'hf, `RESP_OKAY);
    rd_chk(`OFS_IRQ_STATUS, '0, `RESP_OKAY);
    pulse(40'h1 << 14, 40'h1 << 14);
    pulse(40'h1 << 27, 40'h1 << 14);
    rd_chk(`OFS_IRQ_STATUS, 32'h0000_0004, `RESP_OKAY);
    chk_irq(1'b0);
    wr_chk(`OFS_IRQ_MASK, 32'h0000_0004, 4'hf, `RESP_OKAY);
    rd_chk(`OFS_IRQ_MASK, 32'h0000_0004, `RESP_OKAY);
    chk_irq(1'b1);
    // Drop the stream 2 done flag; the sticky record must keep irq up
    wr_chk(`OFS_LOW_CLEAR, 32'h0020_0000, 4'hf, `RESP_OKAY);
    lo[21] = 1'b0;
    pulse('0, 40'h1 << 14);
    chk_irq(1'b1);
    wr_chk(`OFS_IRQ_STATUS, 32'h0000_0004, 4'hf, `RESP_OKAY);
    chk_irq(1'b0);
    rd_chk(`OFS_HIGH_STATUS, hi, `RESP_OKAY);
    results();
  end
endmodule : tb_top
`default_nettype wire
